// *** mtseq_pkg.sv ***
/*
  Constants for the measurement trigger sequencer: register offsets,
  field positions, reset values, source and mode codes, states.
  Assumes a Wishbone slave with 32-bit data and byte addresses.
*/
package mtseq_pkg;
  // Register byte offsets
  localparam logic [7:0] MTS_CTRL_OFS = 8'h00;
  localparam logic [7:0] MTS_CHAN_OFS = 8'h04;
  localparam logic [7:0] MTS_CMD_OFS  = 8'h08;
  localparam logic [7:0] MTS_DLY_OFS  = 8'h0C;
  localparam logic [7:0] MTS_SWP_OFS  = 8'h10;
  localparam logic [7:0] MTS_STIM_OFS = 8'h14;
  localparam logic [7:0] MTS_STAT_OFS = 8'h18;
  // CTRL fields
  localparam int MTS_SRC_LSB   = 0;
  localparam int MTS_POINT_BIT = 2;
  localparam int MTS_POS_BIT   = 3;
  localparam int MTS_SCOPE_BIT = 4;
  localparam int MTS_AVG_BIT   = 5;
  localparam int MTS_AVGT_BIT  = 6;
  localparam int MTS_ACH_LSB   = 8;
  // CHAN fields
  localparam int MTS_MODE_LSB  = 0;
  localparam int MTS_ACT_LSB   = 8;
  localparam int MTS_DISP_LSB  = 12;
  localparam int MTS_PORT_LSB  = 16;
  // SWP fields
  localparam int MTS_NPTS_LSB  = 0;
  localparam int MTS_AVGF_LSB  = 16;
  // CMD bits
  localparam int MTS_CMD_TRIG    = 0;
  localparam int MTS_CMD_RESTART = 1;
  localparam int MTS_CMD_BUS     = 2;
  localparam int MTS_CMD_HOLDALL = 3;
  localparam int MTS_CMD_CONTDSP = 4;
  localparam int MTS_CMD_SINGLE  = 5;
  localparam int MTS_CMD_HOLD    = 6;
  localparam int MTS_CMD_CONT    = 7;
  // Trigger sources
  localparam logic [1:0] MTS_SRC_INT = 2'h0;
  localparam logic [1:0] MTS_SRC_EXT = 2'h1;
  localparam logic [1:0] MTS_SRC_MAN = 2'h2;
  localparam logic [1:0] MTS_SRC_BUS = 2'h3;
  // Channel trigger modes
  localparam logic [1:0] MTS_HOLD   = 2'h0;
  localparam logic [1:0] MTS_SINGLE = 2'h1;
  localparam logic [1:0] MTS_CONT   = 2'h2;
  // Reset values
  localparam logic [3:0]  MTS_RST_ACT   = 4'h1;
  localparam logic [3:0]  MTS_RST_DISP  = 4'h1;
  localparam logic [7:0]  MTS_RST_PORTS = 8'hFF;
  localparam logic [15:0] MTS_RST_NPTS  = 16'h0010;
  localparam logic [9:0]  MTS_RST_AVGF  = 10'h001;
  localparam logic [23:0] MTS_RST_STIME = 24'h000100;
  // Sequencer states
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_DLY  = 4'h2,
    ST_MEAS = 4'h4,
    ST_NEXT = 4'h8
  } mts_state_t;
endpackage

// *** mtseq_top.sv ***
/*
  Measurement trigger sequencer: trigger source and event selection,
  external edge detect, trigger delay, per-point ready interval,
  handler index, per-channel hold/single/continuous modes and scope.
  Assumes a classic Wishbone master on CORE_CLK and asynchronous
  external and handler trigger pins.
*/
`timescale 1ns/10ps
`default_nettype none
module mtseq_top
  import mtseq_pkg::*;
(
  input  wire logic        CORE_CLK,
  input  wire logic        RST_N,
  input  wire logic        WB_CYC_I,
  input  wire logic        WB_STB_I,
  input  wire logic        WB_WE_I,
  input  wire logic [7:0]  WB_ADR_I,
  input  wire logic [3:0]  WB_SEL_I,
  input  wire logic [31:0] WB_DAT_I,
  output logic      [31:0] WB_DAT_O,
  output logic             WB_ACK_O,
  input  wire logic        EXT_TRIG_IN,
  input  wire logic        HANDLER_TRIG_N,
  output logic             HANDLER_INDEX,
  output logic             MEAS_ACTIVE,
  output logic      [1:0]  MEAS_CHANNEL,
  output logic      [1:0]  STIM_PORT_EN
);

  typedef struct packed {
    mts_state_t  st;
    logic [2:0]  ext_s;
    logic        ext_f;
    logic [2:0]  hdl_s;
    logic        hdl_f;
    logic [1:0]  src;
    logic        point_ev;
    logic        pos_edge;
    logic        scope_act;
    logic        avg_on;
    logic        avg_trig;
    logic [1:0]  ach;
    logic [7:0]  modes;
    logic [3:0]  act_m;
    logic [3:0]  disp_m;
    logic [7:0]  ports;
    logic [15:0] dly;
    logic [15:0] npts;
    logic [9:0]  avgf;
    logic [23:0] stime;
    logic [3:0]  pend;
    logic [1:0]  ch;
    logic [15:0] pt;
    logic [9:0]  avgc;
    logic [15:0] cnt;
    logic [24:0] acc;
    logic        index;
    logic        meas;
    logic [1:0]  sport;
    logic        retrig;
    logic        ack;
    logic [31:0] rdat;
  } mts_reg_t;

  localparam mts_reg_t MTS_RST = '{st: ST_IDLE, act_m: MTS_RST_ACT,
    disp_m: MTS_RST_DISP, ports: MTS_RST_PORTS, npts: MTS_RST_NPTS,
    avgf: MTS_RST_AVGF, stime: MTS_RST_STIME, default: '0};

  mts_reg_t q;
  mts_reg_t d;

  // Byte-lane merge for Wishbone writes
  function automatic logic [31:0] mts_lane(input logic [31:0] o,
                                           input logic [31:0] n,
                                           input logic [3:0]  s);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++)
    begin
      if (s[i])
      begin
        r[i*8 +: 8] = n[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // Lowest set channel of a mask
  function automatic logic [1:0] mts_first(input logic [3:0] m);
    logic [1:0] r;
    r = 2'h0;
    for (int i = 3; i >= 0; i--)
    begin
      if (m[i])
      begin
        r = 2'(i);
      end
    end
    return r;
  endfunction

  // Enter a point: delay first when external with a nonzero delay, else measure
  function automatic mts_reg_t mts_go(input mts_reg_t r);
    mts_reg_t x;
    x = r;
    x.acc = '0;
    if (r.src == MTS_SRC_EXT && r.dly != 16'h0000)
    begin
      x.st  = ST_DLY;
      x.cnt = r.dly;
    end
    else
    begin
      x.st = ST_MEAS;
    end
    return x;
  endfunction

  logic        req;
  logic        wr;
  logic        cmd_wr;
  logic [31:0] cmdv;
  logic [31:0] wv;
  logic [31:0] rv;
  logic        ext_edge;
  logic        hdl_edge;
  logic        trig;
  logic        eff_point;
  logic [3:0]  live;
  logic [3:0]  elig;
  logic [3:0]  rem;
  logic        pdone;
  logic        last_pt;
  logic        last_avg;
  logic [9:0]  nsw;
  logic [1:0]  cur_mode;

  // Next-state logic of the whole block
  always_comb
  begin
    d = q;
    // Pin synchronisers; a level counts once stages two and three agree
    d.ext_s = {q.ext_s[1:0], EXT_TRIG_IN};
    d.hdl_s = {q.hdl_s[1:0], HANDLER_TRIG_N};
    ext_edge = 1'b0;
    hdl_edge = 1'b0;
    if (q.ext_s[1] == q.ext_s[2])
    begin
      d.ext_f  = q.ext_s[2];
      ext_edge = (q.ext_s[2] != q.ext_f) && (q.ext_s[2] == q.pos_edge);
    end
    if (q.hdl_s[1] == q.hdl_s[2])
    begin
      d.hdl_f  = q.hdl_s[2];
      hdl_edge = q.hdl_f && !q.hdl_s[2]; // Fixed falling edge
    end

    // Wishbone slave: ack one cycle after request, write on ack edge
    req    = WB_CYC_I && WB_STB_I;
    d.ack  = req && !q.ack;
    wr     = req && q.ack && WB_WE_I;
    cmd_wr = wr && (WB_ADR_I == MTS_CMD_OFS);
    cmdv   = cmd_wr ? mts_lane(32'h0000_0000, WB_DAT_I, WB_SEL_I) : 32'h0000_0000;
    rv     = 32'h0000_0000;
    case (WB_ADR_I)
      MTS_CTRL_OFS:
      begin
        rv[MTS_SRC_LSB +: 2]   = q.src;
        rv[MTS_POINT_BIT]      = q.point_ev;
        rv[MTS_POS_BIT]        = q.pos_edge;
        rv[MTS_SCOPE_BIT]      = q.scope_act;
        rv[MTS_AVG_BIT]        = q.avg_on;
        rv[MTS_AVGT_BIT]       = q.avg_trig;
        rv[MTS_ACH_LSB +: 2]   = q.ach;
      end
      MTS_CHAN_OFS:
      begin
        rv[MTS_MODE_LSB +: 8]  = q.modes;
        rv[MTS_ACT_LSB +: 4]   = q.act_m;
        rv[MTS_DISP_LSB +: 4]  = q.disp_m;
        rv[MTS_PORT_LSB +: 8]  = q.ports;
      end
      MTS_DLY_OFS:  rv[15:0] = q.dly;
      MTS_SWP_OFS:
      begin
        rv[MTS_NPTS_LSB +: 16] = q.npts;
        rv[MTS_AVGF_LSB +: 10] = q.avgf;
      end
      MTS_STIM_OFS: rv[23:0] = q.stime;
      MTS_STAT_OFS: rv = {q.pt, 8'h00, q.ch, q.meas, q.index, q.st};
      default:      rv = 32'h0000_0000;
    endcase
    if (d.ack)
    begin
      d.rdat = rv;
    end
    wv = mts_lane(rv, WB_DAT_I, WB_SEL_I);
    if (wr)
    begin
      case (WB_ADR_I)
        MTS_CTRL_OFS:
        begin
          d.src       = wv[MTS_SRC_LSB +: 2];
          d.point_ev  = wv[MTS_POINT_BIT];
          d.pos_edge  = wv[MTS_POS_BIT];
          d.scope_act = wv[MTS_SCOPE_BIT];
          d.avg_on    = wv[MTS_AVG_BIT];
          d.avg_trig  = wv[MTS_AVGT_BIT];
          d.ach       = wv[MTS_ACH_LSB +: 2];
        end
        MTS_CHAN_OFS:
        begin
          d.modes  = wv[MTS_MODE_LSB +: 8];
          d.act_m  = wv[MTS_ACT_LSB +: 4];
          d.disp_m = wv[MTS_DISP_LSB +: 4];
          d.ports  = wv[MTS_PORT_LSB +: 8];
        end
        MTS_DLY_OFS:  d.dly = wv[15:0];
        MTS_SWP_OFS:
        begin
          d.npts = wv[MTS_NPTS_LSB +: 16];
          d.avgf = wv[MTS_AVGF_LSB +: 10];
        end
        MTS_STIM_OFS: d.stime = wv[23:0];
        default:      d.rdat = d.rdat;
      endcase
    end

    // Mode commands
    if (cmdv[MTS_CMD_HOLDALL])
    begin
      d.modes = 8'h00;
    end
    for (int i = 0; i < 4; i++)
    begin
      if (cmdv[MTS_CMD_CONTDSP] && q.disp_m[i])
      begin
        d.modes[i*2 +: 2] = MTS_CONT;
      end
    end
    if (cmdv[MTS_CMD_SINGLE])
    begin
      d.modes[q.ach*2 +: 2] = MTS_SINGLE;
    end
    if (cmdv[MTS_CMD_HOLD])
    begin
      d.modes[q.ach*2 +: 2] = MTS_HOLD;
    end
    if (cmdv[MTS_CMD_CONT])
    begin
      d.modes[q.ach*2 +: 2] = MTS_CONT;
    end

    // Channel eligibility from activation, mode and scope
    for (int i = 0; i < 4; i++)
    begin
      live[i] = q.act_m[i] && (q.modes[i*2 +: 2] != MTS_HOLD);
      elig[i] = live[i] && (!q.scope_act || q.ach == 2'(i));
    end
    eff_point = q.point_ev && (q.src != MTS_SRC_INT);
    nsw       = (q.avg_on && q.avg_trig && q.avgf != 10'h000) ? q.avgf : 10'h001;
    cur_mode  = d.modes[q.ch*2 +: 2];

    // The single trigger source
    case (q.src)
      MTS_SRC_INT: trig = 1'b1;
      MTS_SRC_EXT: trig = ext_edge || hdl_edge;
      MTS_SRC_MAN: trig = cmdv[MTS_CMD_TRIG];
      MTS_SRC_BUS: trig = cmdv[MTS_CMD_BUS];
      default:     trig = 1'b0;
    endcase

    // Ready interval: accumulate points per cycle up to sweep time
    pdone    = (q.npts == 16'h0000) || ((q.acc + 25'(q.npts)) >= 25'(q.stime));
    last_pt  = (q.pt + 16'h0001) >= q.npts;
    last_avg = (q.avgc + 10'h001) >= nsw;
    rem      = q.pend & ~(4'h1 << q.ch) & live;

    // Sequencer
    case (q.st)
      ST_IDLE:
      begin
        // A pending restart is used up here, so it cannot fire on a later mode change
        d.retrig = 1'b0;
        if ((trig || q.retrig) && elig != 4'h0)
        begin
          d.pend   = elig;
          d.ch     = mts_first(elig);
          d.pt     = 16'h0000;
          d.avgc   = 10'h000;
          d.index  = eff_point;
          d        = mts_go(d);
        end
      end
      ST_DLY:
      begin
        d.cnt = q.cnt - 16'h0001;
        if (q.cnt == 16'h0001)
        begin
          d.st = ST_MEAS;
        end
      end
      ST_MEAS:
      begin
        // Triggers are not looked at while a point runs
        d.acc = q.acc + 25'(q.npts);
        if (pdone)
        begin
          d.pt = q.pt + 16'h0001;
          d.st = eff_point ? ST_NEXT : ST_IDLE;
          if (last_pt)
          begin
            d.pt   = 16'h0000;
            d.avgc = q.avgc + 10'h001;
            if (last_avg)
            begin
              d.avgc = 10'h000;
              if (cur_mode == MTS_SINGLE)
              begin
                d.modes[q.ch*2 +: 2] = MTS_HOLD;
              end
              d.pend = rem; // Finished channel leaves the pending set
              d.ch   = mts_first(rem);
              if (rem == 4'h0)
              begin
                d.st    = ST_IDLE; // Continuous channels retrigger from idle
                d.index = 1'b0;
                d.pend  = 4'h0;
              end
            end
          end
          if (d.st == ST_IDLE && d.pend != 4'h0)
          begin
            d = mts_go(d);
          end
        end
      end
      ST_NEXT:
      begin
        if (trig)
        begin
          d = mts_go(d);
        end
      end
      default: d.st = ST_IDLE;
    endcase

    // Hold stops the running channel at once, a sweep starting now too; restart gives a fresh trigger
    if ((d.st != ST_IDLE && d.modes[d.ch*2 +: 2] == MTS_HOLD) || cmdv[MTS_CMD_RESTART])
    begin
      d.st    = ST_IDLE;
      d.pend  = 4'h0;
      d.index = 1'b0;
    end
    if (cmdv[MTS_CMD_RESTART])
    begin
      d.retrig = 1'b1;
    end

    // Registered outputs
    d.meas  = (d.st == ST_MEAS);
    d.sport = d.meas ? d.ports[d.ch*2 +: 2] : 2'h0;
  end

  // State register
  always_ff @(posedge CORE_CLK)
  begin
    if (!RST_N)
    begin
      q <= MTS_RST;
    end
    else
    begin
      q <= d;
    end
  end

  // Outputs straight from flip-flops
  assign WB_DAT_O      = q.rdat;
  assign WB_ACK_O      = q.ack;
  assign HANDLER_INDEX = q.index;
  assign MEAS_ACTIVE   = q.meas;
  assign MEAS_CHANNEL  = q.ch;
  assign STIM_PORT_EN  = q.sport;

  // Checks
  default clocking mts_cb @(posedge CORE_CLK); endclocking
  default disable iff (!RST_N);

  sequence chan_last_s;
    q.st == ST_MEAS && pdone && last_pt && last_avg;
  endsequence

  sequence start_s;
    q.st == ST_IDLE && (trig || q.retrig) && elig != 4'h0 && !wr;
  endsequence

  bus_ack_pulse_a: assert property (WB_ACK_O |=> !WB_ACK_O)
    else $error("ack held longer than one cycle");
  int_retrig_a: assert property (start_s ##0 q.src == MTS_SRC_INT |=> q.st != ST_IDLE)
    else $error("internal source did not retrigger");
  int_no_point_a: assert property (q.src == MTS_SRC_INT |-> q.st != ST_NEXT)
    else $error("point wait with internal source");
  ext_delay_only_a: assert property (q.st == ST_DLY |-> $past(q.src) == MTS_SRC_EXT)
    else $error("trigger delay without external source");
  point_busy_a: assert property (q.st == ST_MEAS && !pdone |=> q.st inside {ST_MEAS, ST_IDLE})
    else $error("point measurement interrupted by trigger");
  index_rise_a: assert property ($rose(HANDLER_INDEX) |-> $past(eff_point) && MEAS_ACTIVE || q.st == ST_DLY)
    else $error("index rose outside point mode start");
  hold_stop_a: assert property (q.st != ST_IDLE |-> q.modes[q.ch*2 +: 2] != MTS_HOLD)
    else $error("sweep running on a held channel");
  hold_all_stop_a: assert property (cmdv[MTS_CMD_CONT:MTS_CMD_HOLDALL] == 5'h01
    |=> q.st == ST_IDLE && !MEAS_ACTIVE)
    else $error("hold all did not stop the sweep");
  single_back_a: assert property (chan_last_s ##0 (cur_mode == MTS_SINGLE && !wr) |=> q.modes[$past(q.ch)*2 +: 2] == MTS_HOLD)
    else $error("single channel not back in hold");
  start_chan_a: assert property (start_s |=> q.ch == $past(mts_first(elig)) && $past(q.act_m[mts_first(elig)]))
    else $error("sweep started on wrong channel");

endmodule
`default_nettype wire

// *** mtseq_trig_src.sv ***
/*
  Far-side model: external trigger source and handler trigger line.
  Assumes the bench pulses fire inputs for one CORE_CLK cycle.
*/
`timescale 1ns/10ps
`default_nettype none
module mtseq_trig_src (
  input  wire logic       clk,
  input  wire logic       fire_ext,
  input  wire logic       fire_hdl,
  input  wire logic       pulse_high,
  input  wire logic [7:0] width,
  output logic            ext_pin,
  output logic            hdl_n
);
  logic [7:0] ext_q = 8'h00;
  logic [7:0] hdl_q = 8'h00;
  // Pulse length counters, loaded on a fire request
  always @(posedge clk)
  begin
    ext_q <= fire_ext ? width : (ext_q != 8'h00 ? ext_q - 8'h01 : ext_q);
    hdl_q <= fire_hdl ? width : (hdl_q != 8'h00 ? hdl_q - 8'h01 : hdl_q);
  end
  // Pulse level picks which edge leads
  assign ext_pin = (ext_q != 8'h00) ? pulse_high : !pulse_high;
  // Handler line rests high on its pull-up, pulled low while pulsing
  assign hdl_n = (hdl_q == 8'h00);
endmodule
`default_nettype wire

// *** mtseq_top_tb.sv ***
/*
  Self-checking bench for mtseq_top: register rows, then sources, point
  timing, modes, scope and reset. Assumes mtseq_pkg and mtseq_trig_src.
*/
`timescale 1ns/10ps
`default_nettype none
module mtseq_top_tb import mtseq_pkg::*;;
  typedef struct packed {logic [7:0] adr; logic [3:0] sel; logic [31:0] wd; logic [31:0] rd;} mts_row_t;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [3:0]  sel = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic [31:0] r;
  logic        ack;
  logic        ext_pin;
  logic        hdl_n;
  logic        index;
  logic        meas;
  logic [1:0]  mch;
  logic [1:0]  stim;
  logic        fire_e = 1'b0;
  logic        fire_h = 1'b0;
  logic        clr = 1'b0;
  logic        m_q = 1'b0;
  logic [7:0]  width = 8'h04;
  logic [3:0]  seen = 4'h0;
  logic [1:0]  stim_of [4];
  int          rises, hi_len, last_len, lat, r0, mismatches, n_checks;
  logic [1:0]  srcs [3] = '{MTS_SRC_MAN, MTS_SRC_BUS, MTS_SRC_MAN};
  int          cmds [3] = '{MTS_CMD_TRIG, MTS_CMD_BUS, MTS_CMD_RESTART};
  mts_row_t    rows [8] = '{
    '{MTS_CTRL_OFS, 4'hF, 32'h0000_0278, 32'h0000_0278},
    '{MTS_DLY_OFS, 4'hF, 32'h0000_1234, 32'h0000_1234},
    '{MTS_DLY_OFS, 4'h1, 32'h0000_ABCD, 32'h0000_12CD},
    '{MTS_SWP_OFS, 4'hF, 32'h0003_0004, 32'h0003_0004},
    '{MTS_STIM_OFS, 4'hF, 32'h0000_0008, 32'h0000_0008},
    '{MTS_CMD_OFS, 4'hF, 32'h0000_0048, 32'h0000_0000},
    '{MTS_STAT_OFS, 4'hF, 32'h0000_FFFF, 32'h0000_0001},
    '{8'h1C, 4'hF, 32'hFFFF_FFFF, 32'h0000_0000}};

  always #5 clk = ~clk;

  mtseq_top dut (.CORE_CLK(clk), .RST_N(rst_n), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
    .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack),
    .EXT_TRIG_IN(ext_pin), .HANDLER_TRIG_N(hdl_n), .HANDLER_INDEX(index), .MEAS_ACTIVE(meas),
    .MEAS_CHANNEL(mch), .STIM_PORT_EN(stim));

  mtseq_trig_src src (.clk(clk), .fire_ext(fire_e), .fire_hdl(fire_h), .pulse_high(1'b1),
    .width(width), .ext_pin(ext_pin), .hdl_n(hdl_n));

  // Watch measurement: rise count, pulse length, channels and ports seen
  always @(posedge clk)
  begin
    m_q <= meas;
    hi_len <= meas ? hi_len + 1 : 0;
    if (m_q && !meas)
      last_len <= hi_len;
    if (meas && !m_q)
      rises <= rises + 1;
    if (clr)
      seen <= 4'h0;
    else if (meas)
    begin
      seen[mch] <= 1'b1;
      stim_of[mch] <= stim;
    end
  end

  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e)
    begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic ok(input string nm, input logic c);
    chk(nm, {31'h0, c}, 32'h1);
  endtask

  // Classic Wishbone cycle, held until ack is sampled
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s = 4'hF);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= s;
    wdat <= d;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (ack !== 1'b1 && n < 20);
    r = rdat;
    ok("bus ack", n < 20);
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge clk);
  endtask

  task automatic fire(input logic h, input logic [7:0] w);
    width <= w;
    fire_h <= h;
    fire_e <= !h;
    @(posedge clk);
    fire_h <= 1'b0;
    fire_e <= 1'b0;
  endtask

  task automatic wait_meas(input logic lvl);
    lat = 0;
    while (meas !== lvl && lat < 300)
    begin
      @(posedge clk);
      lat++;
    end
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Watchdog well beyond the expected run length
  initial
  begin
    repeat (20000) @(posedge clk);
    mismatches++;
    summarize();
  end

  // Main sequence
  initial
  begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (6) @(posedge clk);
    foreach (rows[i])
    begin
      wb(1'b1, rows[i].adr, rows[i].wd, rows[i].sel);
      wb(1'b0, rows[i].adr, 32'h0);
      chk("register row", r, rows[i].rd);
    end
    $display("test registers done");
    // Internal source with point bit set still sweeps freely
    wb(1'b1, MTS_SWP_OFS, 32'h0001_0002);
    wb(1'b1, MTS_STIM_OFS, 32'h0000_0004);
    wb(1'b1, MTS_CTRL_OFS, 32'h0000_0004);
    r0 = rises;
    wb(1'b1, MTS_CHAN_OFS, 32'h0001_1102);
    repeat (60) @(posedge clk);
    ok("internal repeats", rises - r0 >= 5);
    ok("internal index", index === 1'b0);
    wb(1'b1, MTS_CMD_OFS, 32'h0000_0040);
    ok("hold stops", meas === 1'b0);
    r0 = rises;
    repeat (20) @(posedge clk);
    ok("hold quiet", rises == r0);
    $display("test internal done");
    // External per-point, rising edge, delay 10, 20-cycle points
    wb(1'b1, MTS_DLY_OFS, 32'h0000_000A);
    wb(1'b1, MTS_STIM_OFS, 32'h0000_0028);
    wb(1'b1, MTS_CTRL_OFS, 32'h0000_000D);
    wb(1'b1, MTS_CHAN_OFS, 32'h0001_1101);
    fire(1'b0, 8'h08);
    wait_meas(1'b1);
    ok("ext delay", lat >= 12 && lat <= 18);
    ok("index up", index === 1'b1);
    repeat (3) @(posedge clk);
    fire(1'b0, 8'h04);
    wait_meas(1'b0);
    @(posedge clk);
    chk("point length", last_len, 32'd20);
    repeat (15) @(posedge clk);
    ok("pulse ignored", meas === 1'b0 && index === 1'b1);
    fire(1'b0, 8'h04);
    wait_meas(1'b1);
    wait_meas(1'b0);
    ok("index down", index === 1'b0);
    wb(1'b0, MTS_CHAN_OFS, 32'h0);
    ok("single to hold", r[1:0] === MTS_HOLD);
    // Falling polarity triggers at the end of a wide pulse
    wb(1'b1, MTS_DLY_OFS, 32'h0000_0000);
    wb(1'b1, MTS_CTRL_OFS, 32'h0000_0005);
    wb(1'b1, MTS_CHAN_OFS, 32'h0001_1101);
    fire(1'b0, 8'h1E);
    wait_meas(1'b1);
    ok("falling edge", lat >= 32 && lat <= 38);
    wb(1'b1, MTS_CMD_OFS, 32'h0000_0008);
    ok("hold all stops", meas === 1'b0);
    // Handler line acts on its falling edge whatever the polarity
    wb(1'b1, MTS_CHAN_OFS, 32'h0001_1101);
    wb(1'b1, MTS_CTRL_OFS, 32'h0000_000D);
    fire(1'b1, 8'h1E);
    wait_meas(1'b1);
    ok("handler edge", lat <= 8);
    wb(1'b1, MTS_CMD_OFS, 32'h0000_0008);
    $display("test external done");
    // Manual, bus and restart commands, one-point single sweeps
    wb(1'b1, MTS_SWP_OFS, 32'h0001_0001);
    wb(1'b1, MTS_STIM_OFS, 32'h0000_0008);
    foreach (srcs[i])
    begin
      wb(1'b1, MTS_CTRL_OFS, {30'h0, srcs[i]});
      wb(1'b1, MTS_CHAN_OFS, 32'h0001_1101);
      wb(1'b1, MTS_CMD_OFS, 32'h1 << cmds[i]);
      wait_meas(1'b1);
      ok("command trigger", lat <= 2);
      wait_meas(1'b0);
      wb(1'b0, MTS_CHAN_OFS, 32'h0);
      ok("single done", r[1:0] === MTS_HOLD);
    end
    // Averaging trigger: one manual trigger runs three 8-cycle sweeps back to back
    wb(1'b1, MTS_SWP_OFS, 32'h0003_0001);
    wb(1'b1, MTS_CTRL_OFS, 32'h0000_0062);
    wb(1'b1, MTS_CHAN_OFS, 32'h0001_1101);
    wb(1'b1, MTS_CMD_OFS, 32'h0000_0001);
    wait_meas(1'b1);
    wait_meas(1'b0);
    @(posedge clk);
    chk("avg sweeps", last_len, 32'd24);
    wb(1'b0, MTS_CHAN_OFS, 32'h0);
    ok("avg single done", r[1:0] === MTS_HOLD);
    $display("test commands done");
    // Scope: ch1 active but not displayed, each with its own ports
    wb(1'b1, MTS_CTRL_OFS, 32'h0000_0002);
    wb(1'b1, MTS_CHAN_OFS, 32'h0009_130A);
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    wb(1'b1, MTS_CMD_OFS, 32'h0000_0001);
    repeat (60) @(posedge clk);
    ok("scope all", seen === 4'h3);
    ok("stim ports", stim_of[0] === 2'b01 && stim_of[1] === 2'b10);
    wb(1'b1, MTS_CMD_OFS, 32'h0000_0008);
    wb(1'b1, MTS_CHAN_OFS, 32'h0009_130A);
    wb(1'b1, MTS_CTRL_OFS, 32'h0000_0112);
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    wb(1'b1, MTS_CMD_OFS, 32'h0000_0001);
    repeat (60) @(posedge clk);
    ok("scope active", seen === 4'h2);
    wb(1'b1, MTS_CMD_OFS, 32'h0000_0008);
    wb(1'b0, MTS_CHAN_OFS, 32'h0);
    ok("all held", r[7:0] === 8'h00);
    wb(1'b1, MTS_CMD_OFS, 32'h0000_0010);
    wb(1'b0, MTS_CHAN_OFS, 32'h0);
    ok("displayed cont", r[7:0] === 8'h02);
    wb(1'b1, MTS_CMD_OFS, 32'h0000_0008);
    $display("test scope done");
    // Second reset with the sequencer held idle restores defaults
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    ok("reset quiet", meas === 1'b0 && index === 1'b0);
    wb(1'b0, MTS_CHAN_OFS, 32'h0);
    chk("reset chan", r, 32'h00FF_1100);
    wb(1'b0, MTS_SWP_OFS, 32'h0);
    chk("reset swp", r, 32'h0001_0010);
    wb(1'b0, MTS_STIM_OFS, 32'h0);
    chk("reset stime", r, 32'h0000_0100);
    wb(1'b0, MTS_CTRL_OFS, 32'h0);
    chk("reset ctrl", r, 32'h0000_0000);
    $display("test reset done");
    summarize();
  end
endmodule
`default_nettype wire
